// file: sos_pkg.sv
// Constants and carriers for the safety option status words.
// Assumes the user includes it before every other file of the block.
package sos_pkg;

  // Word one: level bits
  localparam int W1_NORMAL = 0; // Normal operation
  localparam int W1_SELFTEST = 1; // Power-up self test running
  localparam int W1_TORQUE_OFF = 2; // Torque-off function active
  localparam int W1_TIMED_STOP = 3; // Timed safe stop active
  localparam int W1_OUT_LOW = 8; // Safe output at 0 V
  localparam int W1_INIT = 9; // Initialized state
  localparam int W1_ACK_REQ = 10; // Fieldbus acknowledge request
  localparam int W1_INT_FAIL = 11; // Internal failure
  localparam int W1_RST_REQ = 12; // Reset required
  localparam int W1_FS_PEND = 13; // Pending fail-safe state
  localparam int W1_EXT_FAIL = 14; // External failure
  localparam int W1_SF_PEND = 15; // Safety function pending
  // Word one: event bits and error code field
  localparam int W1_GEN_RST = 16; // General reset done
  localparam int W1_CUST_OK = 17; // Customization confirmed
  localparam int W1_CUST_ABORT = 18; // Customization aborted
  localparam int W1_CUST_REQ = 19; // Customization requested
  localparam int W1_ST_WARN = 21; // Self-test warning
  localparam int W1_ERR_LSB = 24; // Error code field
  localparam int ERR_W = 8; // Error code width
  // Word two
  localparam int W2_DIN_LSB = 0; // Safety input state
  localparam int W2_BLANK = 4; // Blank initial state
  localparam int W2_BUS_LSB = 5; // Supported fieldbus code
  localparam int W2_BUS_W = 3; // Width of that code
  localparam int W2_BUS_FUNC = 8; // Function active over fieldbus
  localparam int W2_BUS_COMM = 9; // Fieldbus link established
  // Event latch indexes, matching the packing of sos_evt_s
  localparam int EVT_N = 5;
  localparam int EVT_GEN_RST = 0;
  localparam int EVT_CUST_OK = 1;
  localparam int EVT_CUST_ABORT = 2;
  localparam int EVT_CUST_REQ = 3;
  localparam int EVT_ST_WARN = 4;
  // Reset value and reserved masks
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] W1_RSVD_MASK = 32'h00D0_00F0;
  localparam logic [31:0] W2_RSVD_MASK = 32'hFFFF_FC0C;
  // Highest defined fieldbus code
  localparam logic [2:0] BUS_MAX = 3'h4;
  // Read selector values
  localparam logic SEL_ONE = 1'b0;
  localparam logic SEL_TWO = 1'b1;

  // Safety input state encoding
  typedef enum logic [1:0] {
    SOS_DIN_OFF = 2'h0,
    SOS_DIN_ON = 2'h1,
    SOS_DIN_PEND = 2'h2,
    SOS_DIN_ERR = 2'h3
  } sos_din_e;

  // Level conditions from the safety kernel
  typedef struct packed {
    logic selftest;
    logic torque_off;
    logic timed_stop;
    logic out_low;
    logic initialized;
    logic ack_req;
    logic int_fail;
    logic rst_req;
    logic fs_pend;
    logic ext_fail;
    logic sf_pend;
    logic failsafe_act;
    logic warning;
    logic [ERR_W-1:0] err_code;
  } sos_cond_s;

  // One-cycle event pulses; first field is the top bit
  typedef struct packed {
    logic st_warn;
    logic cust_req;
    logic cust_abort;
    logic cust_ok;
    logic gen_rst;
  } sos_evt_s;

  // Inputs of word two
  typedef struct packed {
    sos_din_e din;
    logic blank;
    logic [W2_BUS_W-1:0] bus_kind;
    logic bus_func;
    logic bus_comm;
  } sos_w2_s;

endpackage

// file: sos_evt_latch.sv
// Sticky event flags, set by pulses and cleared on a read.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sos_evt_latch #(
  parameter int N = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] set,
  input wire logic clr,
  output logic [N-1:0] flags
);

  // Width check
  if (N < 1) begin : g_bad_n
    $error("sos_evt_latch: N must be at least 1");
  end

  // One flag per event; a set in the clearing cycle survives
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge clk) begin
      if (rst) begin
        flags[i] <= 1'b0;
      end else if (set[i]) begin
        flags[i] <= 1'b1;
      end else if (clr) begin
        flags[i] <= 1'b0;
      end
    end
  end

endmodule

// file: sos_word2.sv
// Builds status word two from the input and fieldbus conditions.
// Assumes inputs synchronous to clk; the word lags them by one cycle.
`timescale 1ns/1ps
module sos_word2 #(
  parameter logic [2:0] MAX_CODE = sos_pkg::BUS_MAX
) (
  input wire logic clk,
  input wire logic rst,
  input wire sos_pkg::sos_w2_s w2_in,
  output logic [31:0] word
);

  logic [31:0] next_word; // Word before the register

  // Highest fieldbus code must be nonzero
  if (MAX_CODE == 3'h0) begin : g_bad_max
    $error("sos_word2: MAX_CODE must be nonzero");
  end

  // Pack fields; reserved bits stay zero
  always_comb begin
    next_word = sos_pkg::STATUS_RESET;
    next_word[sos_pkg::W2_DIN_LSB +: 2] = w2_in.din;
    next_word[sos_pkg::W2_BLANK] = w2_in.blank;
    // Undefined codes report no fieldbus rather than a wrong one
    if (w2_in.bus_kind <= MAX_CODE) begin
      next_word[sos_pkg::W2_BUS_LSB +: sos_pkg::W2_BUS_W] = w2_in.bus_kind;
    end
    next_word[sos_pkg::W2_BUS_FUNC] = w2_in.bus_func & w2_in.bus_comm;
    next_word[sos_pkg::W2_BUS_COMM] = w2_in.bus_comm;
  end

  // Word register
  always_ff @(posedge clk) begin
    if (rst) begin
      word <= sos_pkg::STATUS_RESET;
    end else begin
      word <= next_word;
    end
  end

  din_field_a: assert property (@(posedge clk) disable iff (rst)
    1 |=> word[1:0] == $past(w2_in.din)) else $error("input state field wrong");
  bus_func_a: assert property (@(posedge clk) disable iff (rst)
    !w2_in.bus_comm |=> !word[sos_pkg::W2_BUS_FUNC] && !word[sos_pkg::W2_BUS_COMM])
    else $error("fieldbus function shown without link");
  w2_reserved_a: assert property (@(posedge clk) disable iff (rst)
    (word & sos_pkg::W2_RSVD_MASK) == 32'h0000_0000) else $error("word two reserved bit set");

endmodule

// file: sos_status.sv
// Top of the status block: word one, event latching and the read port.
// Assumes the safety kernel drives levels and one-cycle event pulses
// synchronous to REF_CLK, and that reads come from a single reader.
`timescale 1ns/1ps
module sos_status #(
  parameter logic [2:0] BUS_MAX_CODE = sos_pkg::BUS_MAX
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire sos_pkg::sos_cond_s COND,
  input wire sos_pkg::sos_evt_s EVT,
  input wire sos_pkg::sos_w2_s W2_IN,
  input wire logic RD_REQ,
  input wire logic RD_SEL,
  input wire logic WR_REQ,
  output logic [31:0] STATUS_ONE,
  output logic [31:0] STATUS_TWO,
  output logic [31:0] RD_DATA,
  output logic RD_VALID,
  output logic WR_REFUSED
);

  // Fieldbus code must fit its three-bit field
  if (BUS_MAX_CODE > 3'h7 || BUS_MAX_CODE == 3'h0) begin : g_bad_code
    $error("sos_status: BUS_MAX_CODE out of range");
  end

  // Word one as it will be registered
  logic [31:0] next_one;
  // Word two straight from its builder register
  logic [31:0] word_two;
  // Latched events, indexed as in the package
  logic [sos_pkg::EVT_N-1:0] evt_flags;
  // Event pulses as a vector
  logic [sos_pkg::EVT_N-1:0] evt_set;
  // A read of word one clears the latched events
  logic evt_clr;
  // Any reason for bit 0 to drop
  logic stop_any;

  // Pick the word that a read selects
  function automatic logic [31:0] pick_word(
    input logic sel,
    input logic [31:0] one,
    input logic [31:0] two
  );
    pick_word = (sel == sos_pkg::SEL_TWO) ? two : one;
  endfunction

  // Event pulses are packed in latch order
  assign evt_set = EVT;
  // Clear only when the reader fetches word one
  assign evt_clr = RD_REQ && (RD_SEL == sos_pkg::SEL_ONE);

  // Event latches; a pulse in the clearing cycle is kept
  sos_evt_latch #(
    .N(sos_pkg::EVT_N)
  ) u_evt (
    .clk(REF_CLK),
    .rst(RESET),
    .set(evt_set),
    .clr(evt_clr),
    .flags(evt_flags)
  );

  // Second status word builder
  sos_word2 #(
    .MAX_CODE(BUS_MAX_CODE)
  ) u_word2 (
    .clk(REF_CLK),
    .rst(RESET),
    .w2_in(W2_IN),
    .word(word_two)
  );

  // Normal operation drops on any active or pending stop or warning
  always_comb begin
    stop_any = COND.torque_off | COND.timed_stop | COND.sf_pend |
      COND.failsafe_act | COND.fs_pend | COND.warning;
  end

  // Assemble word one from levels, latched events and the error code
  always_comb begin
    // Start from zero so reserved positions stay clear
    next_one = sos_pkg::STATUS_RESET;
    next_one[sos_pkg::W1_NORMAL] = ~stop_any;
    next_one[sos_pkg::W1_SELFTEST] = COND.selftest;
    next_one[sos_pkg::W1_TORQUE_OFF] = COND.torque_off;
    next_one[sos_pkg::W1_TIMED_STOP] = COND.timed_stop;
    // Bit is high when the output sits at 0 V
    next_one[sos_pkg::W1_OUT_LOW] = COND.out_low;
    next_one[sos_pkg::W1_INIT] = COND.initialized;
    next_one[sos_pkg::W1_ACK_REQ] = COND.ack_req;
    next_one[sos_pkg::W1_INT_FAIL] = COND.int_fail;
    next_one[sos_pkg::W1_RST_REQ] = COND.rst_req;
    next_one[sos_pkg::W1_FS_PEND] = COND.fs_pend;
    next_one[sos_pkg::W1_EXT_FAIL] = COND.ext_fail;
    next_one[sos_pkg::W1_SF_PEND] = COND.sf_pend;
    // Events stay up until word one has been read
    next_one[sos_pkg::W1_GEN_RST] = evt_flags[sos_pkg::EVT_GEN_RST];
    next_one[sos_pkg::W1_CUST_OK] = evt_flags[sos_pkg::EVT_CUST_OK];
    next_one[sos_pkg::W1_CUST_ABORT] = evt_flags[sos_pkg::EVT_CUST_ABORT];
    next_one[sos_pkg::W1_CUST_REQ] = evt_flags[sos_pkg::EVT_CUST_REQ];
    next_one[sos_pkg::W1_ST_WARN] = evt_flags[sos_pkg::EVT_ST_WARN];
    // The kernel owns the code; it is passed through unchanged
    next_one[sos_pkg::W1_ERR_LSB +: sos_pkg::ERR_W] = COND.err_code;
  end

  // Process data copy of word one, refreshed every cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      STATUS_ONE <= sos_pkg::STATUS_RESET;
    end else begin
      STATUS_ONE <= next_one;
    end
  end

  // Word two leaves through a top-level register
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      STATUS_TWO <= sos_pkg::STATUS_RESET;
    end else begin
      STATUS_TWO <= word_two;
    end
  end

  // Read port; data is taken from the same value that the
  // latches are cleared against, so no event slips between
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      RD_DATA <= sos_pkg::STATUS_RESET;
    end else if (RD_REQ) begin
      RD_DATA <= pick_word(RD_SEL, next_one, word_two);
    end
  end

  // Read answer strobe, one cycle per request
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_REQ;
    end
  end

  // Writes touch nothing; the attempt is only reported
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      WR_REFUSED <= 1'b0;
    end else begin
      WR_REFUSED <= WR_REQ;
    end
  end

  // Helper: any event pulse this cycle
  logic evt_any;
  assign evt_any = |evt_set;

  // Bit 0 follows the stop conditions one cycle later
  normal_bit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_NORMAL] == !$past(stop_any))
    else $error("normal bit does not match stop conditions");

  // A torque-off forces bit 0 low and bit 2 high together
  torque_off_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    COND.torque_off |=> STATUS_ONE[sos_pkg::W1_TORQUE_OFF] && !STATUS_ONE[sos_pkg::W1_NORMAL])
    else $error("torque-off not reported");

  // Level bits 1, 3 and 8..15 mirror their conditions
  level_bits_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> {STATUS_ONE[sos_pkg::W1_SELFTEST], STATUS_ONE[sos_pkg::W1_TIMED_STOP],
      STATUS_ONE[sos_pkg::W1_OUT_LOW], STATUS_ONE[sos_pkg::W1_INIT],
      STATUS_ONE[sos_pkg::W1_ACK_REQ], STATUS_ONE[sos_pkg::W1_INT_FAIL],
      STATUS_ONE[sos_pkg::W1_RST_REQ], STATUS_ONE[sos_pkg::W1_FS_PEND],
      STATUS_ONE[sos_pkg::W1_EXT_FAIL], STATUS_ONE[sos_pkg::W1_SF_PEND]} ==
      $past({COND.selftest, COND.timed_stop, COND.out_low, COND.initialized,
      COND.ack_req, COND.int_fail, COND.rst_req, COND.fs_pend,
      COND.ext_fail, COND.sf_pend}))
    else $error("level bit mismatch");

  // General reset pulse shows two cycles on, even under a read
  gen_reset_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    EVT.gen_rst |-> ##2 STATUS_ONE[sos_pkg::W1_GEN_RST])
    else $error("general reset event lost");

  // Customization request latches into bit 19
  cust_req_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    EVT.cust_req |-> ##2 STATUS_ONE[sos_pkg::W1_CUST_REQ])
    else $error("customization request lost");

  // A latched warning holds until word one is read
  warn_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    evt_flags[sos_pkg::EVT_ST_WARN] && !evt_clr |=> evt_flags[sos_pkg::EVT_ST_WARN])
    else $error("warning dropped without a read");

  // A read of word one with no new events clears the event bits
  evt_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    evt_clr && !evt_any ##1 !evt_any |=>
      STATUS_ONE[sos_pkg::W1_ST_WARN:sos_pkg::W1_GEN_RST] == 6'h00)
    else $error("events not cleared by read");

  // Error code field passes through unchanged
  err_code_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_ERR_LSB +: sos_pkg::ERR_W] == $past(COND.err_code))
    else $error("error code field wrong");

  // Read answers next cycle with the selected word
  read_data_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    RD_REQ |=> RD_VALID && RD_DATA == pick_word($past(RD_SEL), STATUS_ONE, STATUS_TWO))
    else $error("read answer wrong");

  // A write changes no read data and is flagged
  write_none_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    WR_REQ && !RD_REQ |=> WR_REFUSED && $stable(RD_DATA))
    else $error("write not refused");

  // Reserved bits of word one never rise
  w1_reserved_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (STATUS_ONE & sos_pkg::W1_RSVD_MASK) == 32'h0000_0000)
    else $error("word one reserved bit set");

  // Per-bit checks, one rule each, so a failure names its bit
  // Self test flag follows its condition one cycle later
  selftest_bit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_SELFTEST] == $past(COND.selftest))
    else $error("self test bit wrong");

  // Timed safe stop flag follows its condition
  timed_stop_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_TIMED_STOP] == $past(COND.timed_stop))
    else $error("timed stop bit wrong");

  // High means the safe output sits at 0 V
  out_low_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_OUT_LOW] == $past(COND.out_low))
    else $error("safe output bit wrong");

  // Initialized flag follows its condition
  init_bit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_INIT] == $past(COND.initialized))
    else $error("initialized bit wrong");

  // Acknowledge request follows its condition
  ack_req_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_ACK_REQ] == $past(COND.ack_req))
    else $error("acknowledge request bit wrong");

  // Internal failure follows its condition
  int_fail_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_INT_FAIL] == $past(COND.int_fail))
    else $error("internal failure bit wrong");

  // Reset required follows its condition
  rst_req_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_RST_REQ] == $past(COND.rst_req))
    else $error("reset required bit wrong");

  // Pending fail-safe follows its condition
  fs_pend_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_FS_PEND] == $past(COND.fs_pend))
    else $error("pending fail-safe bit wrong");

  // External failure follows its condition
  ext_fail_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_EXT_FAIL] == $past(COND.ext_fail))
    else $error("external failure bit wrong");

  // Safety function pending follows its condition
  sf_pend_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> STATUS_ONE[sos_pkg::W1_SF_PEND] == $past(COND.sf_pend))
    else $error("function pending bit wrong");

  // Customization confirm latches into bit 17
  cust_ok_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    EVT.cust_ok |-> ##2 STATUS_ONE[sos_pkg::W1_CUST_OK])
    else $error("customization confirm lost");

  // Customization abort latches into bit 18
  cust_abort_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    EVT.cust_abort |-> ##2 STATUS_ONE[sos_pkg::W1_CUST_ABORT])
    else $error("customization abort lost");

  // Self-test warning latches into bit 21
  st_warn_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    EVT.st_warn |-> ##2 STATUS_ONE[sos_pkg::W1_ST_WARN])
    else $error("self-test warning lost");

  // A pulse in the clearing cycle leaves its flag set
  set_wins_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    EVT.gen_rst && evt_clr |=> evt_flags[sos_pkg::EVT_GEN_RST])
    else $error("event lost under a clearing read");

  // A read answer only ever follows a request
  valid_cause_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    RD_VALID |-> $past(RD_REQ))
    else $error("read answer without request");

  // A refusal only ever follows a write attempt
  refuse_cause_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    WR_REFUSED |-> $past(WR_REQ))
    else $error("refusal without write");

  // Blank state reaches word two two cycles after its input
  blank_bit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> ##1 STATUS_TWO[sos_pkg::W2_BLANK] == $past(W2_IN.blank, 2))
    else $error("blank state bit wrong");

  // Link state reaches word two two cycles after its input
  comm_bit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    1 |=> ##1 STATUS_TWO[sos_pkg::W2_BUS_COMM] == $past(W2_IN.bus_comm, 2))
    else $error("link state bit wrong");

  // Main scenarios
  evt_read_c: cover property (@(posedge REF_CLK) disable iff (RESET)
    EVT.cust_ok ##2 evt_clr ##1 RD_VALID);
  set_clear_c: cover property (@(posedge REF_CLK) disable iff (RESET)
    EVT.gen_rst && evt_clr);
  write_try_c: cover property (@(posedge REF_CLK) disable iff (RESET)
    WR_REQ ##1 WR_REFUSED);
  word_two_c: cover property (@(posedge REF_CLK) disable iff (RESET)
    RD_REQ && RD_SEL == sos_pkg::SEL_TWO && W2_IN.bus_comm);
  normal_drop_c: cover property (@(posedge REF_CLK) disable iff (RESET)
    STATUS_ONE[sos_pkg::W1_NORMAL] ##1 !STATUS_ONE[sos_pkg::W1_NORMAL]);

endmodule

// file: sos_reader.sv
// Reader model: a drive controller polling the two status words.
// Assumes the block answers each read with a one-cycle valid pulse.
`timescale 1ns/1ps
module sos_reader (
  input wire logic clk,
  output logic rd_req,
  output logic rd_sel,
  input wire logic [31:0] rd_data,
  input wire logic rd_valid
);
  // Idle request lines at time zero
  initial begin
    rd_req = 1'b0;
    rd_sel = 1'b0;
  end

  // One read; gap idle cycles model a slow poller
  task automatic read(input logic sel, input int gap, output logic [31:0] data);
    int n;
    repeat (gap) @(negedge clk);
    @(negedge clk);
    // Request held across the taking edge
    rd_req = 1'b1;
    rd_sel = sel;
    @(negedge clk);
    rd_req = 1'b0;
    // Select flips so a stale selector is never trusted
    rd_sel = ~sel;
    n = 0;
    // Bounded wait: a missing answer leaves unknown data
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    data = (rd_valid === 1'b1) ? rd_data : 'x;
  endtask
endmodule

// file: test_safety_option_status_words.sv
// Self-checking bench for the safety option status words.
// Assumes the package and design files are compiled before it.
`timescale 1ns/1ps
module test_safety_option_status_words;
  // One table row: conditions, word-two inputs, expected words
  typedef struct {
    logic [20:0] c;
    logic [7:0] w;
    logic [31:0] e1;
    logic [31:0] e2;
  } sos_row_s;

  logic ref_clk = 1'b0; // 250 MHz clock
  logic reset = 1'b1; // Held high at start
  sos_pkg::sos_cond_s cond = '0;
  sos_pkg::sos_evt_s evt = '0;
  sos_pkg::sos_w2_s w2_in = '0;
  logic wr_req = 1'b0;
  logic rd_req;
  logic rd_sel;
  logic [31:0] status_one;
  logic [31:0] status_two;
  logic [31:0] rd_data;
  logic [31:0] got;
  logic rd_valid;
  logic wr_refused;
  int fail_count = 0;
  int tests_run = 0;
  // Event bit positions in word one
  int evb [5] = '{16, 17, 18, 19, 21};
  // One condition per row between an all-clear and an all-set row; bus codes include every defined one and a refused one
  sos_row_s rows [16] = '{
    '{21'h00_0000, 8'hE0, 32'h0000_0001, 32'h0000_0013},
    '{21'h10_0000, 8'h50, 32'h0000_0003, 32'h0000_0081},
    '{21'h08_0000, 8'h14, 32'h0000_0004, 32'h0000_0000},
    '{21'h04_0000, 8'h02, 32'h0000_0008, 32'h0000_0000},
    '{21'h02_0000, 8'h03, 32'h0000_0101, 32'h0000_0300},
    '{21'h01_0000, 8'h01, 32'h0000_0201, 32'h0000_0200},
    '{21'h00_8000, 8'h84, 32'h0000_0401, 32'h0000_0022},
    '{21'h00_4000, 8'h08, 32'h0000_0801, 32'h0000_0040},
    '{21'h00_2000, 8'h0C, 32'h0000_1001, 32'h0000_0060},
    '{21'h00_1000, 8'h00, 32'h0000_2000, 32'h0000_0000},
    '{21'h00_0800, 8'h00, 32'h0000_4001, 32'h0000_0000},
    '{21'h00_0400, 8'h00, 32'h0000_8000, 32'h0000_0000},
    '{21'h00_0200, 8'h00, 32'h0000_0000, 32'h0000_0000},
    '{21'h00_0100, 8'h00, 32'h0000_0000, 32'h0000_0000},
    '{21'h00_00A5, 8'h00, 32'hA500_0001, 32'h0000_0000},
    '{21'h1F_FFFF, 8'hFF, 32'hFF00_FF0E, 32'h0000_0313}
  };

  // Clock: 4 ns period
  always #2 ref_clk = ~ref_clk;

  sos_status u_dut (
    .REF_CLK(ref_clk),
    .RESET(reset),
    .COND(cond),
    .EVT(evt),
    .W2_IN(w2_in),
    .RD_REQ(rd_req),
    .RD_SEL(rd_sel),
    .WR_REQ(wr_req),
    .STATUS_ONE(status_one),
    .STATUS_TWO(status_two),
    .RD_DATA(rd_data),
    .RD_VALID(rd_valid),
    .WR_REFUSED(wr_refused)
  );

  sos_reader u_rd (
    .clk(ref_clk),
    .rd_req(rd_req),
    .rd_sel(rd_sel),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
  );

  // Compare and count; case inequality so unknowns never match
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single place where the run ends
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    #20000;
    fail_count++;
    summarize();
  end

  // Main sequence
  initial begin
    int i;
    int b;
    repeat (8) @(negedge ref_clk);
    check("reset word one", status_one, 32'h0000_0000);
    reset = 1'b0;
    // Table rows; word two lags two cycles, so wait three
    for (i = 0; i < 16; i++) begin
      cond = rows[i].c;
      w2_in = rows[i].w;
      repeat (3) @(negedge ref_clk);
      check("word one", status_one, rows[i].e1);
      check("word two", status_two, rows[i].e2);
      u_rd.read(1'b0, i % 2, got);
      check("read word one", got, rows[i].e1);
      u_rd.read(1'b1, 0, got);
      check("read word two", got, rows[i].e2);
    end
    cond = '0;
    w2_in = '0;
    repeat (3) @(negedge ref_clk);
    // Each event is sticky, survives a word-two read, clears on a word-one read
    for (b = 0; b < 5; b++) begin
      evt = 5'h01 << b;
      @(negedge ref_clk);
      evt = '0;
      @(negedge ref_clk);
      check("event set", status_one, (32'h0000_0001 << evb[b]) | 32'h0000_0001);
      u_rd.read(1'b1, 0, got);
      check("event kept", status_one, (32'h0000_0001 << evb[b]) | 32'h0000_0001);
      u_rd.read(1'b0, 0, got);
      check("event read", got, (32'h0000_0001 << evb[b]) | 32'h0000_0001);
      @(negedge ref_clk);
      check("event cleared", status_one, 32'h0000_0001);
      check("valid ends", {31'h0000_0000, rd_valid}, 32'h0000_0000);
    end
    // A new event in the same cycle as the clearing read must not be lost
    fork
      u_rd.read(1'b0, 0, got);
      begin
        @(negedge ref_clk);
        evt = 5'h01;
        @(negedge ref_clk);
        evt = '0;
      end
    join
    check("read before set", got, 32'h0000_0001);
    @(negedge ref_clk);
    check("set beats clear", status_one, 32'h0001_0001);
    u_rd.read(1'b0, 0, got);
    // Write attempt is refused for one cycle and changes nothing
    wr_req = 1'b1;
    @(negedge ref_clk);
    wr_req = 1'b0;
    check("write refused", {31'h0000_0000, wr_refused}, 32'h0000_0001);
    @(negedge ref_clk);
    check("refusal ends", {31'h0000_0000, wr_refused}, 32'h0000_0000);
    check("word after write", status_one, 32'h0000_0001);
    // Reset in mid-run with every condition and word-two input high
    cond = 21'h1F_FFFF;
    w2_in = 8'hFF;
    repeat (3) @(negedge ref_clk);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("mid reset one", status_one, 32'h0000_0000);
    check("mid reset two", status_two, 32'h0000_0000);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    check("after reset", status_one, 32'hFF00_FF0E);
    check("after reset two", status_two, 32'h0000_0313);
    summarize();
  end
endmodule
